// [ric_pkg.sv]
// shared constants and types of the rtc interrupt and capture control block
package ric_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NUM_CH = 4;

  // register byte offsets
  localparam logic [4:0] OFF_SRC_CTL = 5'h00;
  localparam logic [4:0] OFF_CAP_CTL = 5'h04;
  localparam logic [4:0] OFF_SEC_STAT = 5'h08;
  localparam logic [4:0] OFF_CAP_STAT = 5'h0c;
  localparam logic [4:0] OFF_SNAP_BASE = 5'h10;

  // field positions in rtc_interrupt_source_control / rtc_secondary_status
  localparam int unsigned CNT_BIT = 0;
  localparam int unsigned TICK_BIT = 1;

  // capture channel numbers served, in slot order (pins 0..3)
  localparam int unsigned CH_NUM [NUM_CH] = '{0, 2, 3, 4};

  // reset values and the capture control write mask
  localparam logic [1:0] SRC_CTL_RESET = 2'h0;
  localparam logic [15:0] CAP_CTL_RESET = 16'h0000;
  localparam logic [15:0] CAP_CTL_WMASK = 16'hf7be;

  // capture_channel_control layout, bit 15 down to bit 0
  typedef struct packed {
    logic overwrite;
    logic ie4;
    logic ie3;
    logic ie2;
    logic rsv11;
    logic ie0;
    logic pol4;
    logic pol3;
    logic pol2;
    logic rsv6;
    logic pol0;
    logic en4;
    logic en3;
    logic en2;
    logic en0;
    logic rsv0;
  } ric_cap_ctl_type;

  // per-channel view, slot order {ch4, ch3, ch2, ch0}
  typedef struct packed {
    logic [NUM_CH-1:0] enable;
    logic [NUM_CH-1:0] rise_sel;
    logic [NUM_CH-1:0] irq_en;
  } ric_ch_cfg_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ric_bus_state_type;

endpackage

// [ric_capture_channel.sv]
// one input capture channel: pin sync, edge select, snapshot hold policy
module ric_capture_channel (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic pin_async,
  input wire logic enable,
  input wire logic rise_sel,
  input wire logic overwrite_en,
  input wire logic snap_read,
  input wire logic [15:0] count_value,
  output logic event_pulse,
  output logic [15:0] snapshot,
  output logic unread
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic event_q;
    logic [15:0] snap;
    logic unread;
  } ric_chan_state_type;

  ric_chan_state_type s_q;
  ric_chan_state_type s_d;
  logic edge_seen;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pin_async;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    edge_seen = rise_sel ? (s_q.sync2 & ~s_q.prev) : (~s_q.sync2 & s_q.prev);
    s_d.event_q = enable & edge_seen;
    // a read in the same cycle counts as read, so the new capture lands
    if (snap_read) begin
      s_d.unread = 1'b0;
    end
    if (enable && edge_seen) begin
      if (overwrite_en || !s_q.unread || snap_read) begin
        s_d.snap = count_value;
        s_d.unread = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_pulse = s_q.event_q;
  assign snapshot = s_q.snap;
  assign unread = s_q.unread;

  a_snap_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !overwrite_en && s_q.unread && !snap_read |=> $stable(s_q.snap))
    else $error("unread snapshot replaced with overwrite off");

  a_snap_overwrite: assert property (@(posedge clk_sys) disable iff (!reset_n)
    overwrite_en && enable && edge_seen |=> s_q.snap == $past(count_value))
    else $error("snapshot not replaced with overwrite on");

endmodule

// [ric_rtc_irq_capture.sv]
// rtc interrupt source enables and capture channel control, avalon slave
module ric_rtc_irq_capture #(
  parameter bit EXTENDED = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ric_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic count_event,
  input wire logic tick_event,
  input wire logic [15:0] count_value,
  input wire logic [ric_pkg::NUM_CH-1:0] ext_irq_pin,
  output logic irq_cpu,
  output logic irq_wakeup
);

  typedef struct packed {
    ric_pkg::ric_bus_state_type bus_state;
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0] src_ctl;
    ric_pkg::ric_cap_ctl_type cap_ctl;
    logic [1:0] sec_stat;
    logic [ric_pkg::NUM_CH-1:0] cap_stat;
    logic irq_cpu;
    logic irq_wake;
  } ric_main_state_type;

  ric_main_state_type s_q;
  ric_main_state_type s_d;

  ric_pkg::ric_ch_cfg_type cfg;
  logic [ric_pkg::NUM_CH-1:0] cap_evt;
  logic [ric_pkg::NUM_CH-1:0] cap_unread;
  logic [ric_pkg::NUM_CH-1:0] snap_read;
  logic [15:0] snap [ric_pkg::NUM_CH];
  logic wr_done;
  logic [15:0] wr_val;
  logic [15:0] src_wr;

  // snapshot slot hit, used by the read mux and the read-side effect
  function automatic logic snap_hit(
    input logic [ric_pkg::ADDR_W-1:0] addr,
    input int unsigned slot
  );
    logic [ric_pkg::ADDR_W-1:0] want;
    want = ric_pkg::OFF_SNAP_BASE + ric_pkg::ADDR_W'(slot * 4);
    return addr == want;
  endfunction

  // byte-lane merge on the 16 implemented bits
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // per-channel view of the control word, slot 3 is channel 4
  always_comb begin
    cfg.enable = {s_q.cap_ctl.en4, s_q.cap_ctl.en3,
                  s_q.cap_ctl.en2, s_q.cap_ctl.en0};
    cfg.rise_sel = {s_q.cap_ctl.pol4, s_q.cap_ctl.pol3,
                    s_q.cap_ctl.pol2, s_q.cap_ctl.pol0};
    cfg.irq_en = {s_q.cap_ctl.ie4, s_q.cap_ctl.ie3,
                  s_q.cap_ctl.ie2, s_q.cap_ctl.ie0};
  end

  // slot i serves channel CH_NUM[i] from pin i
  genvar gi;
  generate
    for (gi = 0; gi < ric_pkg::NUM_CH; gi++) begin : g_ch
      assign snap_read[gi] = (s_q.bus_state == ric_pkg::BUS_IDLE) &&
                             avs_read && snap_hit(avs_address, gi);
      ric_capture_channel u_chan (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_async(ext_irq_pin[gi]),
        .enable(cfg.enable[gi]),
        .rise_sel(cfg.rise_sel[gi]),
        .overwrite_en(s_q.cap_ctl.overwrite),
        .snap_read(snap_read[gi]),
        .count_value(count_value),
        .event_pulse(cap_evt[gi]),
        .snapshot(snap[gi]),
        .unread(cap_unread[gi])
      );
    end
  endgenerate

  assign wr_done = (s_q.bus_state == ric_pkg::BUS_ACK) && avs_write;
  assign wr_val = merge16(16'h0000, avs_writedata, avs_byteenable);
  assign src_wr = merge16({14'h0000, s_q.src_ctl}, avs_writedata,
                          avs_byteenable);

  always_comb begin
    s_d = s_q;
    // bus handshake: take in idle, answer one cycle later, then release
    case (s_q.bus_state)
      ric_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_d.bus_state = ric_pkg::BUS_ACK;
          s_d.waitreq = 1'b0;
          s_d.rdata = 32'h0000_0000;
          if (avs_read) begin
            case (avs_address)
              ric_pkg::OFF_SRC_CTL: begin
                s_d.rdata[1:0] = EXTENDED ? s_q.src_ctl : 2'h0;
              end
              ric_pkg::OFF_CAP_CTL: begin
                s_d.rdata[15:0] = EXTENDED ? 16'(s_q.cap_ctl) :
                                  ric_pkg::CAP_CTL_RESET;
              end
              ric_pkg::OFF_SEC_STAT: begin
                s_d.rdata[1:0] = s_q.sec_stat;
              end
              ric_pkg::OFF_CAP_STAT: begin
                for (int i = 0; i < ric_pkg::NUM_CH; i++) begin
                  s_d.rdata[ric_pkg::CH_NUM[i]] = s_q.cap_stat[i];
                  s_d.rdata[8 + ric_pkg::CH_NUM[i]] = cap_unread[i];
                end
              end
              default: begin
                for (int i = 0; i < ric_pkg::NUM_CH; i++) begin
                  if (snap_hit(avs_address, i)) begin
                    s_d.rdata[15:0] = snap[i];
                  end
                end
              end
            endcase
          end
        end
      end
      ric_pkg::BUS_ACK: begin
        s_d.bus_state = ric_pkg::BUS_IDLE;
        s_d.waitreq = 1'b1;
      end
      default: begin
        s_d.bus_state = ric_pkg::BUS_IDLE;
        s_d.waitreq = 1'b1;
      end
    endcase

    // writes land at the edge where waitrequest is seen low
    if (wr_done && EXTENDED) begin
      if (avs_address == ric_pkg::OFF_SRC_CTL) begin
        s_d.src_ctl = src_wr[1:0];
      end
      if (avs_address == ric_pkg::OFF_CAP_CTL) begin
        s_d.cap_ctl = merge16(16'(s_q.cap_ctl), avs_writedata,
                              avs_byteenable) & ric_pkg::CAP_CTL_WMASK;
      end
    end

    // sticky flags: write one to clear, a same-cycle event wins
    if (wr_done && avs_address == ric_pkg::OFF_SEC_STAT) begin
      s_d.sec_stat = s_q.sec_stat & ~wr_val[1:0];
    end
    if (wr_done && avs_address == ric_pkg::OFF_CAP_STAT) begin
      for (int i = 0; i < ric_pkg::NUM_CH; i++) begin
        if (wr_val[ric_pkg::CH_NUM[i]]) begin
          s_d.cap_stat[i] = 1'b0;
        end
      end
    end
    s_d.sec_stat[ric_pkg::CNT_BIT] = s_d.sec_stat[ric_pkg::CNT_BIT] |
                                     count_event;
    s_d.sec_stat[ric_pkg::TICK_BIT] = s_d.sec_stat[ric_pkg::TICK_BIT] |
                                      tick_event;
    s_d.cap_stat = s_d.cap_stat | cap_evt;

    // capture flags feed both lines; count and tick only the cpu line
    // next-state enables are used so a write-enable acts on the same edge
    s_d.irq_wake = |(s_d.cap_stat & {s_d.cap_ctl.ie4, s_d.cap_ctl.ie3,
                                     s_d.cap_ctl.ie2, s_d.cap_ctl.ie0});
    s_d.irq_cpu = (|(s_d.sec_stat & s_d.src_ctl)) | s_d.irq_wake;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{bus_state: ric_pkg::BUS_IDLE,
               waitreq: 1'b1,
               rdata: 32'h0000_0000,
               src_ctl: ric_pkg::SRC_CTL_RESET,
               cap_ctl: ric_pkg::CAP_CTL_RESET,
               sec_stat: 2'h0,
               cap_stat: '0,
               irq_cpu: 1'b0,
               irq_wake: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign irq_cpu = s_q.irq_cpu;
  assign irq_wakeup = s_q.irq_wake;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  a_bus_answer: assert property (
    s_q.bus_state == ric_pkg::BUS_IDLE && (avs_read || avs_write)
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  a_tick_gate: assert property (
    s_q.sec_stat[ric_pkg::TICK_BIT] && s_q.src_ctl[ric_pkg::TICK_BIT]
    |-> irq_cpu)
    else $error("enabled tick flag missing from irq");

  a_basic_zero: assert property (!EXTENDED |-> s_q.src_ctl == 2'h0)
    else $error("basic instance holds interrupt enables");

  a_count_gate: assert property (
    s_q.sec_stat[ric_pkg::CNT_BIT] && s_q.src_ctl[ric_pkg::CNT_BIT]
    |-> irq_cpu)
    else $error("enabled count flag missing from irq");

  a_basic_ctl: assert property (
    !EXTENDED |-> 16'(s_q.cap_ctl) == ric_pkg::CAP_CTL_RESET)
    else $error("basic instance capture control moved");

  a_pin_flag: assert property (cap_evt[3] |=> s_q.cap_stat[3])
    else $error("capture event did not set its flag");

  a_ch4_gate: assert property (s_q.cap_stat[3] && s_q.cap_ctl.ie4
    |-> irq_cpu && irq_wakeup)
    else $error("channel 4 flag not on both lines");

  a_ch3_gate: assert property (s_q.cap_stat[2] && s_q.cap_ctl.ie3
    |-> irq_cpu && irq_wakeup)
    else $error("channel 3 flag not on both lines");

  a_ch4_off: assert property (!s_q.cap_ctl.en4 |=> !cap_evt[3])
    else $error("disabled channel 4 raised an event");

  a_irq_quiet: assert property (!irq_cpu
    |-> (s_q.sec_stat & s_q.src_ctl) == 2'h0 &&
        (s_q.cap_stat & cfg.irq_en) == '0)
    else $error("irq low with an enabled flag set");

  c_read_done: cover property (avs_read && !avs_waitrequest);
  c_wake_rise: cover property ($rose(irq_wakeup));
  c_held_snap: cover property (cap_evt[3] && !s_q.cap_ctl.overwrite);

endmodule

// [ric_rtc_irq_capture_bench.sv]
// self-checking bench for the rtc interrupt and capture control block
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module ric_rtc_irq_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic [31:0] avs_readdata_b;
  logic [31:0] q;
  logic [31:0] rd_basic;
  logic avs_waitrequest;
  logic count_event = 1'b0;
  logic tick_event = 1'b0;
  logic [15:0] count_value = 16'h0000;
  logic [3:0] ext_irq_pin = 4'h0;
  logic irq_cpu;
  logic irq_wakeup;
  int errors = 0;
  int compares = 0;

  always #5 clk_sys = ~clk_sys;

  ric_rtc_irq_capture #(.EXTENDED(1'b1)) i_ric_rtc_irq_capture (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_event(count_event), .tick_event(tick_event),
    .count_value(count_value), .ext_irq_pin(ext_irq_pin),
    .irq_cpu(irq_cpu), .irq_wakeup(irq_wakeup));

  // basic instance shares the bus requests; its answers come in the same cycle as the main one's
  ric_rtc_irq_capture #(.EXTENDED(1'b0)) i_ric_rtc_irq_capture_basic (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata_b), .avs_waitrequest(),
    .count_event(count_event), .tick_event(tick_event),
    .count_value(count_value), .ext_irq_pin(ext_irq_pin),
    .irq_cpu(), .irq_wakeup());

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [15:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("wrong value at %0t: bus never answered", $time);
    end
    q = avs_readdata;
    rd_basic = avs_readdata_b;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(q, {16'h0000, e})
  endtask

  // rising edge then falling edge; only rising is selected in the tests
  task automatic pin(input int i);
    ext_irq_pin[i] <= 1'b1;
    cyc(8);
    ext_irq_pin[i] <= 1'b0;
    cyc(8);
  endtask

  task automatic pulse_ev(input logic tick);
    if (tick) tick_event <= 1'b1;
    else count_event <= 1'b1;
    @(posedge clk_sys);
    tick_event <= 1'b0;
    count_event <= 1'b0;
    cyc(2);
  endtask

  task automatic stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // run needs well under 3000 cycles
  initial begin
    cyc(20000);
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test;
  end

  initial begin
    logic [15:0] exp;
    cyc(16);
    reset_n <= 1'b1;
    cyc(2);
    rd(5'h00, 16'h0000);
    rd(5'h04, ric_pkg::CAP_CTL_RESET);
    wr(5'h04, 16'hffff);
    rd(5'h04, 16'hf7be);
    `CHK(rd_basic, {16'h0000, ric_pkg::CAP_CTL_RESET})
    wr(5'h00, 16'h0003);
    rd(5'h00, 16'h0003);
    `CHK(rd_basic, 32'h0000_0000)
    wr(5'h04, 16'h0000);
    wr(5'h00, 16'h0000);
    pulse_ev(1'b0);
    `CHK({irq_cpu, irq_wakeup}, 2'b00)
    wr(5'h00, 16'h0001);
    `CHK({irq_cpu, irq_wakeup}, 2'b10)
    pulse_ev(1'b1);
    rd(5'h08, 16'h0003);
    // tick flag still set but not enabled
    wr(5'h08, 16'h0001);
    `CHK({irq_cpu, irq_wakeup}, 2'b00)
    wr(5'h00, 16'h0002);
    `CHK({irq_cpu, irq_wakeup}, 2'b10)
    wr(5'h08, 16'h0002);
    `CHK({irq_cpu, irq_wakeup}, 2'b00)
    rd(5'h08, 16'h0000);
    wr(5'h04, 16'h03be);
    exp = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      count_value <= 16'h1000 + 16'(i);
      pin(i);
      exp |= (16'h0001 << ric_pkg::CH_NUM[i]);
      exp |= (16'h0100 << ric_pkg::CH_NUM[i]);
      rd(5'h0c, exp);
    end
    for (int i = 0; i < 4; i++) rd(5'h10 + 5'(4 * i), 16'h1000 + 16'(i));
    wr(5'h0c, 16'h001d);
    rd(5'h0c, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      pin(3 - j);
      `CHK({irq_cpu, irq_wakeup}, 2'b00)
      wr(5'h04, 16'h03be | (16'h4000 >> j));
      `CHK({irq_cpu, irq_wakeup}, 2'b11)
      wr(5'h0c, 16'h0010 >> j);
      `CHK({irq_cpu, irq_wakeup}, 2'b00)
    end
    // channel 4 switched off: a pin edge must leave no flag
    wr(5'h04, 16'h43ae);
    pin(3);
    `CHK({irq_cpu, irq_wakeup}, 2'b00)
    wr(5'h04, 16'h03be);
    count_value <= 16'haaaa;
    pin(0);
    count_value <= 16'h5555;
    pin(0);
    rd(5'h10, 16'haaaa);
    pin(0);
    rd(5'h10, 16'h5555);
    wr(5'h04, 16'h83be);
    count_value <= 16'h1111;
    pin(0);
    count_value <= 16'h2222;
    pin(0);
    rd(5'h10, 16'h2222);
    wr(5'h04, 16'h07be);
    `CHK({irq_cpu, irq_wakeup}, 2'b11)
    wr(5'h0c, 16'h0001);
    `CHK({irq_cpu, irq_wakeup}, 2'b00)
    stop_test;
  end
endmodule
